// *** rtl/adc_link_pkg.sv ***
// Shared constants, command codes and helpers of the converter serial link
package adc_link_pkg;

  // ****************************************
  // Sizes and counts
  // ****************************************
  localparam int WORD_W          = 32;
  localparam int SHORT_W         = 24;
  localparam int BYTE_W          = 8;
  localparam int CNT_W           = 8;
  localparam int TIMEOUT_PERIODS = 64;
  localparam int UPDATE_CLKS     = 4;
  localparam int HALF_DIV        = 4;
  localparam int FLUSH_BITS      = 3;

  // ****************************************
  // Command bytes (values are our own choice)
  // ****************************************
  localparam logic [7:0] OP_NOP     = 8'h00;
  localparam logic [7:0] OP_WAKEUP  = 8'h02;
  localparam logic [7:0] OP_STANDBY = 8'h04;
  localparam logic [7:0] OP_CONTINUOUS_READ      = 8'h10;
  localparam logic [7:0] OP_STOP_CONTINUOUS_READ = 8'h11;
  localparam logic [7:0] OP_RDATA   = 8'h12;
  localparam logic [2:0] OP_REG_RD  = 3'h1;
  localparam logic [2:0] OP_REG_WR  = 3'h2;

  // ****************************************
  // Result codes
  // ****************************************
  localparam logic [31:0] CLIP_POS = 32'h7FFFFFFF;
  localparam logic [31:0] CLIP_NEG = 32'h80000000;

  // ****************************************
  // Gray helpers for counters crossing clocks
  // ****************************************
  function automatic logic [CNT_W-1:0] bin2gray(input logic [CNT_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b = g;
    for (int i = CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// *** rtl/adc_link_if.sv ***
// Serial link wires between the converter and its host
`timescale 1ns/1ps
interface adc_link_if;
  logic sclk;
  logic din;
  logic dout;
  logic result_ready_n;

  modport device (input sclk, input din, output dout, output result_ready_n);
  modport host   (output sclk, output din, input dout, input result_ready_n);
endinterface

// *** rtl/adc_serial_dev.sv ***
// Converter end of the serial read-out link
// How it works
// - Sample input on rising, shift output on falling.
// - Sixty-four idle data periods reset the interface.
// - Host keeps serial clock low when idle.
// - Host keeps input low during continuous reads.
// - Pin mode ignores the serial input.
// - Data ready low marks a new result.
// - Continuous reads finish before next update; the device overwrites an unfinished one.
// - Command reads survive a following update.
// - First falling serial edge releases data ready.
// - Unread results pulse data ready high four clocks.
// - 32-bit word; FIR path: LSB repeats sign, clip codes.
// - Host may stop reading after 24 bits.
// - Sinc path halves the result scaling.
// - Sinc codes do not saturate at half scale.
// - Continuous read after reset and on command.
// - Continuous mode shows MSB as data ready falls.
// - Output low after all 32 bits.
// - Stop command blocks data ready, reads by command.
// - Read command taken on eighth rising edge.
// - Commanded read answered within one data period.
// - Host one-shot: wake, wait, read, standby.
// - Single-byte commands; register access adds bytes.
`timescale 1ns/1ps
module adc_serial_dev (
  // Master clock and reset
  input  wire logic                               clk_i,
  input  wire logic                               reset_n_i,
  // Serial link, clocked by the host
  adc_link_if.device                              link,
  // Converter core side
  input  wire logic [adc_link_pkg::WORD_W-2:0]    sample_i,
  input  wire logic                               sample_valid_i,
  input  wire logic                               clip_pos_i,
  input  wire logic                               clip_neg_i,
  input  wire logic                               sinc_mode_i,
  input  wire logic                               pin_mode_i,
  // Status and command report
  output logic                                    cont_mode_o,
  output logic                                    standby_o,
  output logic [7:0]                              cmd_byte_o,
  output logic                                    cmd_valid_o
);

  localparam int CW = adc_link_pkg::CNT_W;

  typedef enum logic [2:0] {
    CMD_OPCODE = 3'b001,
    CMD_COUNT  = 3'b010,
    CMD_SKIP   = 3'b100
  } cmd_state_t;

  // ****************************************
  // Link clock domain
  // ****************************************
  logic [1:0]    lrst_r;
  logic [1:0]    pin_r;
  logic [CW-1:0] rise_cnt_r;
  logic [CW-1:0] rise_gray_r;
  logic [CW-1:0] fall_cnt_r;
  logic [CW-1:0] fall_gray_r;
  logic [7:0]    shift_r;
  logic [7:0]    rx_byte_r;
  logic          rx_tgl_r;
  // Bases are written by the master-clock side only: rise base before the first sample or on timeout, fall base also at each word load
  logic [CW-1:0] rise_base_r;
  logic [CW-1:0] fall_base_r;
  logic [31:0]   word_r;

  wire [CW-1:0] rise_cnt_nxt = rise_cnt_r + 1'b1;
  wire          din_eff      = link.din & ~pin_r[1];
  wire [7:0]    shift_nxt    = {shift_r[6:0], din_eff};
  wire [CW-1:0] bits_in      = rise_cnt_nxt - rise_base_r;
  wire          byte_end     = (bits_in[2:0] == 3'h0) & ~pin_r[1];
  wire [CW-1:0] out_idx      = fall_cnt_r - fall_base_r;
  wire          out_live     = out_idx < CW'(adc_link_pkg::WORD_W);
  wire [4:0]    out_sel      = 5'h1F - out_idx[4:0];

  // MSB shows as soon as a word is loaded, later bits follow falling edges
  assign link.dout = out_live ? word_r[out_sel] : 1'b0;

  always_ff @(posedge link.sclk) begin
    lrst_r <= {lrst_r[0], reset_n_i};
    pin_r  <= {pin_r[0], pin_mode_i};
    if (!lrst_r[1]) begin
      rise_cnt_r  <= '0;
      rise_gray_r <= '0;
      shift_r     <= 8'h00;
      rx_byte_r   <= 8'h00;
      rx_tgl_r    <= 1'b0;
    end else begin
      rise_cnt_r  <= rise_cnt_nxt;
      rise_gray_r <= adc_link_pkg::bin2gray(rise_cnt_nxt);
      shift_r     <= shift_nxt;
      if (byte_end) begin
        rx_byte_r <= shift_nxt;
        rx_tgl_r  <= ~rx_tgl_r;
      end
    end
  end

  always_ff @(negedge link.sclk) begin
    if (!lrst_r[1]) begin
      fall_cnt_r  <= '0;
      fall_gray_r <= '0;
    end else begin
      fall_cnt_r  <= fall_cnt_r + 1'b1;
      fall_gray_r <= adc_link_pkg::bin2gray(fall_cnt_r + 1'b1);
    end
  end

  // ****************************************
  // Crossing into the master clock
  // ****************************************
  logic [1:0][CW-1:0] rise_s_r;
  logic [1:0][CW-1:0] fall_s_r;
  logic [2:0]         tgl_s_r;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rise_s_r <= '0;
      fall_s_r <= '0;
      tgl_s_r  <= 3'h0;
    end else begin
      rise_s_r <= {rise_s_r[0], rise_gray_r};
      fall_s_r <= {fall_s_r[0], fall_gray_r};
      tgl_s_r  <= {tgl_s_r[1:0], rx_tgl_r};
    end
  end

  wire [CW-1:0] rise_now = adc_link_pkg::gray2bin(rise_s_r[1]);
  wire [CW-1:0] fall_now = adc_link_pkg::gray2bin(fall_s_r[1]);
  wire          rx_new   = tgl_s_r[2] ^ tgl_s_r[1];

  // ****************************************
  // Command decode
  // ****************************************
  cmd_state_t cmd_st_r;
  logic [5:0] skip_r;
  logic       cont_r;
  logic       standby_r;
  logic       read_pend_r;
  logic       init_r;
  logic [6:0] idle_cnt_r;
  logic       act_r;
  logic [CW-1:0] rise_prev_r;

  wire op_live    = rx_new & (cmd_st_r == CMD_OPCODE);
  wire is_cont_cmd = op_live & (rx_byte_r == adc_link_pkg::OP_CONTINUOUS_READ);
  wire is_stop_cmd = op_live & (rx_byte_r == adc_link_pkg::OP_STOP_CONTINUOUS_READ);
  wire is_rdata   = op_live & (rx_byte_r == adc_link_pkg::OP_RDATA);
  wire is_standby = op_live & (rx_byte_r == adc_link_pkg::OP_STANDBY);
  wire is_wakeup  = op_live & (rx_byte_r == adc_link_pkg::OP_WAKEUP);
  wire is_reg     = op_live & ((rx_byte_r[7:5] == adc_link_pkg::OP_REG_RD) |
                               (rx_byte_r[7:5] == adc_link_pkg::OP_REG_WR));
  wire act_now    = rise_now != rise_prev_r;
  wire timeout    = sample_valid_i & ~act_r & ~act_now &
                    (idle_cnt_r == 7'(adc_link_pkg::TIMEOUT_PERIODS - 1));
  wire rebase     = init_r | timeout;
  logic upd_last;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cmd_st_r    <= CMD_OPCODE;
      skip_r      <= 6'h00;
      cont_r      <= 1'b1;
      standby_r   <= 1'b0;
      read_pend_r <= 1'b0;
      cmd_byte_o  <= 8'h00;
      cmd_valid_o <= 1'b0;
    end else begin
      cmd_valid_o <= op_live;
      if (op_live) begin
        cmd_byte_o <= rx_byte_r;
      end
      if (timeout) begin
        cmd_st_r <= CMD_OPCODE;
      end else if (rx_new) begin
        case (cmd_st_r)
          CMD_OPCODE: if (is_reg) begin
            cmd_st_r <= CMD_COUNT;
          end
          CMD_COUNT: begin
            skip_r   <= 6'(rx_byte_r[4:0]) + 6'h01;
            cmd_st_r <= CMD_SKIP;
          end
          CMD_SKIP: begin
            skip_r <= skip_r - 6'h01;
            if (skip_r == 6'h01) begin
              cmd_st_r <= CMD_OPCODE;
            end
          end
          default: cmd_st_r <= CMD_OPCODE;
        endcase
      end
      if (is_cont_cmd) begin
        cont_r <= 1'b1;
      end else if (is_stop_cmd) begin
        cont_r <= 1'b0;
      end
      if (is_standby) begin
        standby_r <= 1'b1;
      end else if (is_wakeup) begin
        standby_r <= 1'b0;
      end
      // A read command arriving with the load it waits for is kept
      if (is_rdata) begin
        read_pend_r <= 1'b1;
      end else if (upd_last) begin
        read_pend_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Idle timeout, counted in data periods
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      init_r      <= 1'b1;
      idle_cnt_r  <= 7'h00;
      act_r       <= 1'b0;
      rise_prev_r <= '0;
    end else begin
      rise_prev_r <= rise_now;
      if (sample_valid_i) begin
        init_r <= 1'b0;
      end
      if (sample_valid_i) begin
        act_r <= 1'b0;
      end else if (act_now) begin
        act_r <= 1'b1;
      end
      if (sample_valid_i) begin
        if (act_r | act_now | timeout) begin
          idle_cnt_r <= 7'h00;
        end else begin
          idle_cnt_r <= idle_cnt_r + 7'h01;
        end
      end
    end
  end

  // ****************************************
  // Result formatting and data ready
  // ****************************************
  logic [31:0] stage_r;
  logic [2:0]  upd_cnt_r;
  logic        defer_r;
  logic        ready_n_r;

  wire [31:0] fir_word  = clip_pos_i ? adc_link_pkg::CLIP_POS :
                          clip_neg_i ? adc_link_pkg::CLIP_NEG :
                          {sample_i, sample_i[30]};
  wire [31:0] sinc_word = {sample_i[30], sample_i};
  wire [31:0] fmt_word  = sinc_mode_i ? sinc_word : fir_word;

  wire [CW-1:0] rd_idx  = fall_now - fall_base_r;
  wire          busy    = (rd_idx != '0) & (rd_idx < CW'(adc_link_pkg::WORD_W));
  wire          new_smp = sample_valid_i & ~standby_r & (cont_r | read_pend_r);
  wire          hold    = new_smp & ~cont_r & busy;
  wire          go_upd  = (new_smp & ~hold) | (defer_r & ~busy & ~new_smp);
  wire          blocked = is_stop_cmd | is_standby;
  assign upd_last = upd_cnt_r == 3'h1;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      stage_r     <= 32'h00000000;
      word_r      <= 32'h00000000;
      upd_cnt_r   <= 3'h0;
      defer_r     <= 1'b0;
      ready_n_r   <= 1'b1;
      rise_base_r <= '0;
      fall_base_r <= '0;
    end else begin
      if (new_smp) begin
        stage_r <= fmt_word;
      end
      // A later result while a command read is shifting waits for its end
      if (hold) begin
        defer_r <= 1'b1;
      end else if (go_upd) begin
        defer_r <= 1'b0;
      end
      // Continuous mode overwrites even an unfinished read
      if (go_upd) begin
        upd_cnt_r <= 3'(adc_link_pkg::UPDATE_CLKS);
      end else if (upd_cnt_r != 3'h0) begin
        upd_cnt_r <= upd_cnt_r - 3'h1;
      end
      if (upd_last) begin
        word_r <= stage_r;
      end
      if (rebase) begin
        rise_base_r <= rise_now;
      end
      if (upd_last | rebase) begin
        fall_base_r <= fall_now;
      end
      if (blocked) begin
        ready_n_r <= 1'b1;
      end else if (upd_last) begin
        ready_n_r <= 1'b0;
      end else if (go_upd) begin
        ready_n_r <= 1'b1;
      end else if (fall_now != fall_base_r) begin
        ready_n_r <= 1'b1;
      end
    end
  end

  assign link.result_ready_n = ready_n_r;
  assign cont_mode_o         = cont_r;
  assign standby_o           = standby_r;

endmodule // adc_serial_dev

// *** rtl/adc_serial_host.sv ***
// Host end of the serial read-out link
`timescale 1ns/1ps
module adc_serial_host #(
  parameter int HALF_DIV = adc_link_pkg::HALF_DIV
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Serial link, clock made here
  adc_link_if.host         link,
  // Command bytes
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_byte_i,
  output logic             cmd_ready_o,
  // Result reads
  input  wire logic        read_req_i,
  input  wire logic        auto_read_i,
  input  wire logic        short_read_i,
  input  wire logic        oneshot_i,
  output logic [31:0]      result_o,
  output logic             result_valid_o,
  output logic             busy_o
);

  typedef enum logic [1:0] {
    H_IDLE  = 2'b01,
    H_SHIFT = 2'b10
  } host_state_t;

  typedef enum logic [3:0] {
    OS_OFF   = 4'b0001,
    OS_WAKE  = 4'b0010,
    OS_READ  = 4'b0100,
    OS_SLEEP = 4'b1000
  } oneshot_t;

  host_state_t st_r;
  oneshot_t    os_r;
  logic        sclk_r;
  logic        din_r;
  logic        rst_seen_r;
  logic [7:0]  div_r;
  logic [5:0]  bits_r;
  logic [7:0]  tx_r;
  logic [31:0] rx_r;
  logic        rd_r;
  logic        short_r;
  logic        wait_r;
  logic        fell_r;
  logic [2:0]  rdy_s_r;
  logic [1:0]  dout_s_r;

  // ****************************************
  // Start decisions
  // ****************************************
  wire idle     = st_r == H_IDLE;
  wire rdy_low  = ~rdy_s_r[1];
  wire rdy_fell = rdy_s_r[2] & ~rdy_s_r[1];
  wire start_rd = idle & (fell_r | (wait_r & rdy_low) | ((os_r == OS_READ) & rdy_low));
  wire start_os = idle & ~start_rd & ((os_r == OS_WAKE) | (os_r == OS_SLEEP));
  wire start_rq = idle & ~start_rd & ~start_os & read_req_i & ~wait_r;
  assign cmd_ready_o = idle & ~start_rd & ~start_os & ~start_rq;
  wire start_cmd = cmd_ready_o & cmd_valid_i;
  wire start_tx  = start_os | start_rq | start_cmd;
  wire [7:0] tx_sel = start_os ? ((os_r == OS_WAKE) ? adc_link_pkg::OP_WAKEUP : adc_link_pkg::OP_STANDBY) :
                      start_rq ? adc_link_pkg::OP_RDATA : cmd_byte_i;
  wire half_end  = div_r == 8'(HALF_DIV - 1);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdy_s_r  <= 3'h7;
      dout_s_r <= 2'h0;
    end else begin
      rdy_s_r  <= {rdy_s_r[1:0], link.result_ready_n};
      dout_s_r <= {dout_s_r[0], link.dout};
    end
  end

  // ****************************************
  // Sequencer and clock divider
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      // Clock runs during reset so the far end's link logic can reset
      rst_seen_r <= 1'b1;
      if (rst_seen_r) begin
        sclk_r <= ~sclk_r;
      end else begin
        sclk_r <= 1'b0;
      end
      st_r           <= H_SHIFT;
      os_r           <= OS_OFF;
      din_r          <= 1'b0;
      div_r          <= 8'h00;
      bits_r         <= 6'(adc_link_pkg::FLUSH_BITS);
      tx_r           <= 8'h00;
      rx_r           <= 32'h00000000;
      rd_r           <= 1'b0;
      short_r        <= 1'b0;
      wait_r         <= 1'b0;
      fell_r         <= 1'b0;
      result_o       <= 32'h00000000;
      result_valid_o <= 1'b0;
    end else begin
      rst_seen_r     <= 1'b0;
      result_valid_o <= 1'b0;
      // A new fall in the start cycle must not be lost
      if (rdy_fell & auto_read_i) begin
        fell_r <= 1'b1;
      end else if (start_rd) begin
        fell_r <= 1'b0;
      end
      if (start_rq) begin
        wait_r <= 1'b1;
      end else if (start_rd) begin
        wait_r <= 1'b0;
      end
      if (oneshot_i & (os_r == OS_OFF)) begin
        os_r <= OS_WAKE;
      end else if (start_os) begin
        os_r <= (os_r == OS_WAKE) ? OS_READ : OS_OFF;
      end else if (start_rd & (os_r == OS_READ)) begin
        os_r <= OS_SLEEP;
      end
      case (st_r)
        H_IDLE: begin
          sclk_r <= 1'b0;
          div_r  <= 8'h00;
          if (start_rd) begin
            st_r    <= H_SHIFT;
            rd_r    <= 1'b1;
            short_r <= short_read_i;
            bits_r  <= short_read_i ? 6'(adc_link_pkg::SHORT_W) : 6'(adc_link_pkg::WORD_W);
            tx_r    <= 8'h00;
            din_r   <= 1'b0;
          end else if (start_tx) begin
            st_r   <= H_SHIFT;
            rd_r   <= 1'b0;
            bits_r <= 6'(adc_link_pkg::BYTE_W);
            tx_r   <= {tx_sel[6:0], 1'b0};
            din_r  <= tx_sel[7];
          end
        end
        H_SHIFT: begin
          if (!half_end) begin
            div_r <= div_r + 8'h01;
          end else begin
            div_r <= 8'h00;
            if (!sclk_r) begin
              sclk_r <= 1'b1;
              rx_r   <= {rx_r[30:0], dout_s_r[1]};
            end else begin
              sclk_r <= 1'b0;
              bits_r <= bits_r - 6'h01;
              if (bits_r == 6'h01) begin
                st_r  <= H_IDLE;
                din_r <= 1'b0;
                if (rd_r) begin
                  result_valid_o <= 1'b1;
                  result_o <= short_r ? {rx_r[23:0], 8'h00} : rx_r;
                end
              end else begin
                din_r <= tx_r[7];
                tx_r  <= {tx_r[6:0], 1'b0};
              end
            end
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_r;
  assign link.din  = din_r;
  assign busy_o    = ~idle;

endmodule // adc_serial_host

// *** sim/adc_link_asserts.sv ***
// Link-level assertions for the converter serial read-out
`timescale 1ns/1ps
module adc_link_asserts #(
  parameter int HALF_DIV = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Link wires
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic result_ready_n
);
  // ****************************************
  // Edge counters
  // ****************************************
  logic [3:0] up_r;
  logic [7:0] hi_r;
  logic [7:0] lo_r;
  logic [7:0] falls_r;
  wire        settled = up_r == 4'hF;

  // Reset-time sclk toggling must not count as a bit
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      up_r    <= 4'h0;
      hi_r    <= 8'h00;
      lo_r    <= 8'h00;
      falls_r <= 8'h00;
    end else begin
      up_r    <= settled ? up_r : up_r + 4'h1;
      hi_r    <= sclk ? hi_r + 8'h01 : 8'h00;
      lo_r    <= sclk ? 8'h00 : lo_r + {7'h00, lo_r != 8'hFF};
      falls_r <= $fell(result_ready_n) ? 8'h00 : falls_r + {7'h00, $fell(sclk) && falls_r != 8'hFF};
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_ready_release: assert property ((!result_ready_n)[*5] ##0 (settled && $fell(sclk)) |-> ##[1:6] result_ready_n)
    else $error("ready stayed low after sclk fall");
  a_ready_pulse: assert property (settled && $rose(result_ready_n) |-> result_ready_n[*3])
    else $error("ready high pulse too short");
  a_ready_hold: assert property (settled && $fell(result_ready_n) |-> (!result_ready_n)[*2])
    else $error("ready low glitch");
  a_dout_steady: assert property (settled && sclk && $past(sclk) && $stable(result_ready_n) |-> $stable(dout))
    else $error("dout moved while sclk high");
  a_dout_tail: assert property (settled && $fell(sclk) && falls_r >= 8'h20 |-> !dout)
    else $error("dout not low after word");
  a_sclk_high: assert property (settled && $fell(sclk) |-> hi_r == 8'(HALF_DIV))
    else $error("sclk high phase wrong");
  a_sclk_low: assert property (settled && $rose(sclk) |-> lo_r >= 8'(HALF_DIV))
    else $error("sclk low phase short");
  a_din_steady: assert property (settled && sclk && $past(sclk) |-> $stable(din))
    else $error("din moved while sclk high");
endmodule // adc_link_asserts

// *** sim/tb_top.sv ***
// Testbench: host end and converter end joined over the serial link
`timescale 1ns/1ps
module tb_top;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int HALF = 4;
  logic        clk_i = 1'b0, reset_n_i = 1'b0, sample_valid_i = 1'b0, clip_pos_i = 1'b0, clip_neg_i = 1'b0;
  logic        sinc_mode_i = 1'b0, pin_mode_i = 1'b0, cmd_valid_i = 1'b0, read_req_i = 1'b0;
  logic        auto_read_i = 1'b0, short_read_i = 1'b0, oneshot_i = 1'b0;
  logic [30:0] sample_i = 31'h0;
  logic [7:0]  cmd_byte_i = 8'h00;
  logic        cont_mode_o, standby_o, cmd_ready_o, result_valid_o, busy_o;
  logic [7:0]  cmd_byte_o;
  logic [31:0] result_o;
  int          num_errors = 0, comparisons = 0, seed = 8;

  adc_link_if link_if ();
  adc_serial_dev adc_serial_dev_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(link_if.device),
    .sample_i(sample_i), .sample_valid_i(sample_valid_i), .clip_pos_i(clip_pos_i), .clip_neg_i(clip_neg_i),
    .sinc_mode_i(sinc_mode_i), .pin_mode_i(pin_mode_i), .cont_mode_o(cont_mode_o), .standby_o(standby_o),
    .cmd_byte_o(cmd_byte_o), .cmd_valid_o());
  adc_serial_host #(.HALF_DIV(HALF)) adc_serial_host_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .link(link_if.host), .cmd_valid_i(cmd_valid_i), .cmd_byte_i(cmd_byte_i), .cmd_ready_o(cmd_ready_o),
    .read_req_i(read_req_i), .auto_read_i(auto_read_i), .short_read_i(short_read_i), .oneshot_i(oneshot_i),
    .result_o(result_o), .result_valid_o(result_valid_o), .busy_o(busy_o));
  adc_link_asserts #(.HALF_DIV(HALF)) adc_link_asserts_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .sclk(link_if.sclk), .din(link_if.din), .dout(link_if.dout), .result_ready_n(link_if.result_ready_n));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic tally_and_finish();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timed_out(input string what);
    num_errors++;
    $display("BAD %s expected event seen timeout", what);
    tally_and_finish();
  endtask

  // Polls at the falling edge so registered outputs have settled
  task automatic wait_for(input int which, input logic lvl, input int limit);
    int n;
    n = 0;
    comparisons++;
    @(negedge clk_i);
    while ((which == 0 ? busy_o : which == 1 ? result_valid_o : link_if.result_ready_n) !== lvl) begin
      n++;
      if (n > limit) timed_out("wait");
      @(negedge clk_i);
    end
  endtask

  function automatic logic [31:0] expect_word(input logic [30:0] raw, input logic cp, input logic cn);
    logic [31:0] w;
    w = sinc_mode_i ? {raw[30], raw} : cp ? adc_link_pkg::CLIP_POS : cn ? adc_link_pkg::CLIP_NEG : {raw, raw[30]};
    if (short_read_i) w[7:0] = 8'h00;
    return w;
  endfunction

  function automatic logic [30:0] rnd();
    return 31'($random(seed));
  endfunction

  // ****************************************
  // Stimulus tasks
  // ****************************************
  task automatic push(input logic [30:0] raw, input logic cp, input logic cn);
    @(posedge clk_i);
    sample_i <= raw;
    clip_pos_i <= cp;
    clip_neg_i <= cn;
    sample_valid_i <= 1'b1;
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
  endtask

  task automatic conv(input logic [30:0] raw, input logic cp, input logic cn);
    push(raw, cp, cn);
    wait_for(1, 1'b1, 900);
    cmp("result_o", expect_word(raw, cp, cn), result_o);
    wait_for(0, 1'b0, 900);
    repeat (40) @(posedge clk_i);
  endtask

  // Commands take effect a few clocks after the eighth rising sclk
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_byte_i <= b;
    @(negedge clk_i);
    while (cmd_ready_o !== 1'b1) begin
      n++;
      if (n > 900) timed_out("cmd_ready_o");
      @(negedge clk_i);
    end
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    wait_for(0, 1'b0, 900);
    repeat (8) @(posedge clk_i);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [30:0] raw;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (60) @(posedge clk_i);
    cmp("cont_mode_o", 32'h1, 32'(cont_mode_o));
    auto_read_i <= 1'b1;
    conv(31'h0, 1'b1, 1'b0);
    conv(31'h0, 1'b0, 1'b1);
    for (int i = 0; i < 5; i++) begin
      conv(rnd(), 1'b0, 1'b0);
    end
    short_read_i <= 1'b1;
    conv(rnd(), 1'b0, 1'b0);
    short_read_i <= 1'b0;
    sinc_mode_i <= 1'b1;
    conv(31'h3FFFFFFF, 1'b0, 1'b0);
    conv(31'h40000000, 1'b0, 1'b0);
    conv(rnd(), 1'b1, 1'b0);
    sinc_mode_i <= 1'b0;
    auto_read_i <= 1'b0;
    push(rnd(), 1'b0, 1'b0);
    wait_for(2, 1'b0, 40);
    push(rnd(), 1'b0, 1'b0);
    wait_for(2, 1'b1, 8);
    wait_for(2, 1'b0, 8);
    @(posedge clk_i);
    auto_read_i <= 1'b1;
    conv(rnd(), 1'b0, 1'b0);
    auto_read_i <= 1'b0;
    send(adc_link_pkg::OP_STOP_CONTINUOUS_READ);
    cmp("cont_mode_o", 32'h0, 32'(cont_mode_o));
    cmp("cmd_byte_o", 32'(adc_link_pkg::OP_STOP_CONTINUOUS_READ), 32'(cmd_byte_o));
    raw = rnd();
    push(raw, 1'b0, 1'b0);
    repeat (8) @(posedge clk_i);
    cmp("result_ready_n", 32'h1, 32'(link_if.result_ready_n));
    read_req_i <= 1'b1;
    @(posedge clk_i);
    read_req_i <= 1'b0;
    repeat (100) @(posedge clk_i);
    push(raw, 1'b0, 1'b0);
    wait_for(0, 1'b1, 40);
    push(rnd(), 1'b0, 1'b0);
    wait_for(1, 1'b1, 900);
    cmp("result_o", expect_word(raw, 1'b0, 1'b0), result_o);
    wait_for(0, 1'b0, 900);
    repeat (40) @(posedge clk_i);
    send(adc_link_pkg::OP_CONTINUOUS_READ);
    cmp("cont_mode_o", 32'h1, 32'(cont_mode_o));
    auto_read_i <= 1'b1;
    conv(rnd(), 1'b0, 1'b1);
    send(8'h40);
    send(8'h00);
    send(adc_link_pkg::OP_STANDBY);
    cmp("standby_o", 32'h0, 32'(standby_o));
    pin_mode_i <= 1'b1;
    send(adc_link_pkg::OP_STANDBY);
    cmp("standby_o", 32'h0, 32'(standby_o));
    pin_mode_i <= 1'b0;
    send(adc_link_pkg::OP_STANDBY);
    cmp("standby_o", 32'h1, 32'(standby_o));
    auto_read_i <= 1'b0;
    oneshot_i <= 1'b1;
    @(posedge clk_i);
    oneshot_i <= 1'b0;
    repeat (120) @(posedge clk_i);
    cmp("standby_o", 32'h0, 32'(standby_o));
    conv(rnd(), 1'b0, 1'b0);
    wait_for(0, 1'b0, 900);
    repeat (8) @(posedge clk_i);
    cmp("standby_o", 32'h1, 32'(standby_o));
    tally_and_finish();
  end
endmodule // tb_top
